// *** design/lbd_alu.sv ***
// Data path: AND, single-bit clear and result flags
`timescale 1ns/1ps
`default_nettype none
`include "lbd_defs.svh"

module lbd_alu (
  // Operation and operands
  input wire lbd_pkg::lbd_op_e op_in,
  input wire logic [7:0] w_in,
  input wire logic [7:0] lit_in,
  input wire logic [7:0] file_in,
  input wire logic [2:0] bitsel_in,
  // Result
  output logic [7:0] result_out,
  output logic neg_out,
  output logic zero_out
);
  import lbd_pkg::*;

  logic [7:0] keep_mask;

  // RL8 one cleared lane
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_mask
      assign keep_mask[gi] = (bitsel_in != 3'(gi));
    end
  endgenerate

  always_comb begin
    case (op_in)
      // RL1 literal with W
      OP_AND_LIT: result_out = w_in & lit_in;
      // RL3 file with W
      OP_AND_FILE: result_out = w_in & file_in;
      OP_BCLR: result_out = file_in & keep_mask;
      default: result_out = file_in;
    endcase
  end

  // RL16 sign and zero
  assign neg_out = result_out[`LBD_SIGN_POS];
  assign zero_out = (result_out == 8'h00);

endmodule // lbd_alu
`default_nettype wire

// *** design/lbd_core.sv ***
// Four-phase execute unit for literal/file AND, carry/negative branch, bit clear
`timescale 1ns/1ps
`default_nettype none
`include "lbd_defs.svh"

// Behaviour
// RL1: Literal AND combines 8-bit immediate with W, result to W; upper byte 0x0b.
// RL2: Register AND opcode 000101, then destination bit, bank bit, 8-bit address.
// RL3: Register AND forms W AND the addressed file register.
// RL4: Destination 0 sends result to W, file register untouched.
// RL5: Destination 1 writes the result back into the file register.
// RL6: Both ANDs update only negative and zero; carry, digit carry, overflow kept.
// RL7: Bank bit 0 uses the access bank; 1 uses the bank-select register.
// RL8: Bit clear zeroes bit b of the file register; opcode nibble 1001.
// RL9: Carry branch opcode upper byte 0xe2 with signed 8-bit offset.
// RL10: Carry branch taken only when carry is one, else fall through.
// RL11: Negative branch, upper byte 0xe6, taken only when negative is one.
// RL12: Taken branch loads incremented PC plus twice the sign-extended offset.
// RL13: One word each; branches take one cycle, two when taken, second idle.
// RL14: Branches and bit clear leave every status flag unchanged.
// RL15: Quarter phases: decode, operand read, process, write result or PC.
// RL16: Negative equals result bit 7; zero set when the result is all zero.
module lbd_core #(
  parameter int PC_W = 21
) (
  // Clock, reset, enable
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic ce_in,
  // Program memory
  input wire logic [15:0] instr_in,
  output logic fetch_out,
  output logic [PC_W-1:0] pc_out,
  // Data memory
  input wire logic [3:0] bank_sel_in,
  input wire logic [7:0] mem_rdata_in,
  output lbd_pkg::lbd_mem_req_s mem_req_out,
  // Loads from the rest of the core
  input wire logic w_load_in,
  input wire logic [7:0] w_data_in,
  input wire logic flag_load_in,
  input wire lbd_pkg::lbd_stat_s flag_data_in,
  // State
  output logic [7:0] w_out,
  output lbd_pkg::lbd_stat_s status_out,
  output lbd_pkg::lbd_phase_e phase_out,
  output logic taken_out,
  output logic nop_cycle_out,
  output logic unknown_op_out
);
  import lbd_pkg::*;

  generate
    if (PC_W < 10) begin : g_pc_check
      $error("PC_W too small for the branch offset");
    end
  endgenerate

  lbd_phase_e phase_ff;
  lbd_phase_e nxt_phase;
  logic [15:0] ir_ff;
  logic [PC_W-1:0] pc_ff;
  logic [PC_W-1:0] nxt_pc_branch;
  logic flush_ff;
  logic take_ff;
  logic nxt_take;
  logic [7:0] w_ff;
  lbd_stat_s status_ff;
  logic [7:0] result_ff;
  logic res_neg_ff;
  logic res_zero_ff;
  lbd_mem_req_s mem_ff;
  logic [11:0] nxt_addr;
  lbd_dec_s dec;
  logic [7:0] alu_result;
  logic alu_neg;
  logic alu_zero;
  logic is_and;
  logic needs_file;

  lbd_decode u_decode (
    .ir_in(ir_ff),
    .dec_out(dec)
  );

  lbd_alu u_alu (
    .op_in(dec.op),
    .w_in(w_ff),
    .lit_in(ir_ff[7:0]),
    .file_in(mem_rdata_in),
    .bitsel_in(dec.bitsel),
    .result_out(alu_result),
    .neg_out(alu_neg),
    .zero_out(alu_zero)
  );

  assign is_and = (dec.op == OP_AND_LIT) || (dec.op == OP_AND_FILE);
  assign needs_file = (dec.op == OP_AND_FILE) || (dec.op == OP_BCLR);

  // ----------------------------------------------------------------------
  // Quarter-phase sequencer
  // ----------------------------------------------------------------------
  // RL15 four quarter phases
  always_comb begin
    case (phase_ff)
      PH_Q1: nxt_phase = PH_Q2;
      PH_Q2: nxt_phase = PH_Q3;
      PH_Q3: nxt_phase = PH_Q4;
      PH_Q4: nxt_phase = PH_Q1;
      default: nxt_phase = PH_Q1;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      phase_ff <= PH_Q1;
    end else if (ce_in) begin
      phase_ff <= nxt_phase;
    end
  end

  // ----------------------------------------------------------------------
  // Q1: instruction latch and PC advance
  // ----------------------------------------------------------------------
  // RL13 idle second cycle
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      ir_ff <= `LBD_IR_RST;
    end else if (ce_in && phase_ff == PH_Q1) begin
      ir_ff <= flush_ff ? `LBD_IR_RST : instr_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      flush_ff <= 1'b0;
    end else if (ce_in && phase_ff == PH_Q4) begin
      flush_ff <= take_ff;
    end
  end

  // RL12 offset doubled, signed
  assign nxt_pc_branch = pc_ff + {{(PC_W-9){ir_ff[`LBD_SIGN_POS]}}, ir_ff[7:0], 1'b0};

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      pc_ff <= '0;
    end else if (ce_in && phase_ff == PH_Q1 && !flush_ff) begin
      pc_ff <= pc_ff + PC_W'(`LBD_PC_STEP);
    end else if (ce_in && phase_ff == PH_Q4 && take_ff) begin
      pc_ff <= nxt_pc_branch;
    end
  end

  // ----------------------------------------------------------------------
  // Q2: file address and read strobe
  // ----------------------------------------------------------------------
  // RL7 access bank override
  always_comb begin
    if (dec.bank_bit) begin
      nxt_addr = {bank_sel_in, dec.fadr};
    end else if (dec.fadr < `LBD_ACCESS_SPLIT) begin
      nxt_addr = {`LBD_ACCESS_LO_BANK, dec.fadr};
    end else begin
      nxt_addr = {`LBD_ACCESS_HI_BANK, dec.fadr};
    end
  end

  // RL5 write back to file
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      mem_ff <= '0;
    end else if (ce_in) begin
      case (phase_ff)
        PH_Q2: begin
          mem_ff.addr <= nxt_addr;
          mem_ff.rd <= needs_file;
        end
        PH_Q3: begin
          mem_ff.rd <= 1'b0;
          mem_ff.we <= dec.writes_file;
          mem_ff.wdata <= alu_result;
        end
        PH_Q4: mem_ff.we <= 1'b0;
        default: mem_ff.rd <= 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Q3: process data, branch decision
  // ----------------------------------------------------------------------
  // RL10 carry condition
  // RL11 negative condition
  always_comb begin
    case (dec.op)
      OP_BR_C: nxt_take = status_ff.c;
      OP_BR_N: nxt_take = status_ff.n;
      default: nxt_take = 1'b0;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      take_ff <= 1'b0;
      result_ff <= 8'h00;
      res_neg_ff <= 1'b0;
      res_zero_ff <= 1'b0;
    end else if (ce_in && phase_ff == PH_Q3) begin
      take_ff <= nxt_take;
      result_ff <= alu_result;
      res_neg_ff <= alu_neg;
      res_zero_ff <= alu_zero;
    end else if (ce_in && phase_ff == PH_Q4) begin
      take_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Q4: W and status write
  // ----------------------------------------------------------------------
  // Instruction results win over a load in the same cycle
  // RL4 result to W
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      w_ff <= `LBD_W_RST;
    end else if (ce_in && phase_ff == PH_Q4 && is_and && !dec.writes_file) begin
      w_ff <= result_ff;
    end else if (ce_in && w_load_in) begin
      w_ff <= w_data_in;
    end
  end

  // RL6 only N and Z
  // RL14 others untouched
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      status_ff <= `LBD_STAT_RST;
    end else if (ce_in && phase_ff == PH_Q4 && is_and) begin
      status_ff.n <= res_neg_ff;
      status_ff.z <= res_zero_ff;
    end else if (ce_in && flag_load_in) begin
      status_ff <= flag_data_in;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign fetch_out = (phase_ff == PH_Q1) && !flush_ff;
  assign pc_out = pc_ff;
  assign mem_req_out = mem_ff;
  assign w_out = w_ff;
  assign status_out = status_ff;
  assign phase_out = phase_ff;
  assign taken_out = take_ff;
  assign nop_cycle_out = flush_ff;
  assign unknown_op_out = (dec.op == OP_NONE) && !flush_ff;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  sequence s_q3(lbd_op_e o);
    ce_in && phase_ff == PH_Q3 && dec.op == o;
  endsequence

  sequence s_q4_taken;
    ce_in && phase_ff == PH_Q4 && take_ff;
  endsequence

  // RL15 phase wraps
  phase_wrap_a: assert property ( // RL15
    (ce_in && phase_ff == PH_Q4) |=> phase_ff == PH_Q1)
    else $error("phase did not wrap to Q1");

  freeze_state_a: assert property (
    !ce_in |=> $stable(pc_ff) && $stable(w_ff) && $stable(phase_ff))
    else $error("state moved while enable low");

  // RL1 literal into W
  and_literal_a: assert property ( // RL1
    s_q3(OP_AND_LIT) ##1 ce_in |=> w_ff == ($past(w_ff, 2) & ir_ff[7:0]))
    else $error("literal AND result wrong in W");

  // RL4 W destination
  and_to_w_a: assert property ( // RL4
    (s_q3(OP_AND_FILE) ##0 !ir_ff[`LBD_DEST_POS]) |=> !mem_req_out.we)
    else $error("register AND with W destination wrote memory");

  // RL5 file destination
  and_to_file_a: assert property ( // RL5
    (s_q3(OP_AND_FILE) ##0 ir_ff[`LBD_DEST_POS]) |=>
      mem_req_out.we && mem_req_out.wdata == ($past(w_ff) & $past(mem_rdata_in)))
    else $error("register AND write-back wrong");

  // RL6 flag update
  and_flags_a: assert property ( // RL6
    (ce_in && phase_ff == PH_Q4 && is_and) |=>
      status_ff.n == $past(result_ff[7]) && status_ff.z == ($past(result_ff) == 8'h00)
      && $stable(status_ff.c) && $stable(status_ff.dc) && $stable(status_ff.ov))
    else $error("AND flags wrong");

  // RL8 bit cleared
  bit_clear_a: assert property ( // RL8
    s_q3(OP_BCLR) |=> mem_req_out.we
      && mem_req_out.wdata == ($past(mem_rdata_in) & ~(8'h01 << $past(dec.bitsel))))
    else $error("bit clear result wrong");

  // RL7 banked address
  bank_select_a: assert property ( // RL7
    (ce_in && phase_ff == PH_Q2 && needs_file && dec.bank_bit) |=>
      mem_req_out.rd && mem_req_out.addr == {$past(bank_sel_in), ir_ff[7:0]})
    else $error("bank-select address wrong");

  // RL12 branch target
  branch_target_a: assert property ( // RL12
    s_q4_taken |=> pc_ff == $past(nxt_pc_branch) ##1 flush_ff[*3])
    else $error("branch target or idle cycle wrong");

  // RL10 no carry, no branch
  carry_clear_a: assert property ( // RL10
    (s_q3(OP_BR_C) ##0 !status_ff.c) |=> !take_ff)
    else $error("carry branch taken with carry clear");

  // RL14 flags kept
  flags_kept_a: assert property ( // RL14
    (ce_in && phase_ff == PH_Q4 && !is_and && !flag_load_in) |=> $stable(status_ff))
    else $error("flags changed by branch or bit clear");

endmodule // lbd_core
`default_nettype wire

// *** design/lbd_decode.sv ***
// Instruction word decoder for the five supported instructions
`timescale 1ns/1ps
`default_nettype none
`include "lbd_defs.svh"

module lbd_decode (
  // Instruction word
  input wire logic [15:0] ir_in,
  // Decoded fields
  output lbd_pkg::lbd_dec_s dec_out
);
  import lbd_pkg::*;

  always_comb begin
    dec_out = '0;
    dec_out.op = OP_NONE;
    dec_out.bank_bit = ir_in[`LBD_BANK_POS];
    dec_out.bitsel = ir_in[`LBD_BSEL_HI:`LBD_BSEL_LO];
    dec_out.fadr = ir_in[7:0];
    // RL1 literal AND match
    if (ir_in[15:8] == `LBD_OPC_AND_LIT) begin
      dec_out.op = OP_AND_LIT;
    // RL2 register AND match
    end else if (ir_in[15:10] == `LBD_OPC_AND_FILE) begin
      dec_out.op = OP_AND_FILE;
      dec_out.writes_file = ir_in[`LBD_DEST_POS];
    // RL9 carry branch match
    end else if (ir_in[15:8] == `LBD_OPC_BR_C) begin
      dec_out.op = OP_BR_C;
    // RL11 negative branch match
    end else if (ir_in[15:8] == `LBD_OPC_BR_N) begin
      dec_out.op = OP_BR_N;
    // RL8 bit clear match
    end else if (ir_in[15:12] == `LBD_OPC_BCLR) begin
      dec_out.op = OP_BCLR;
      dec_out.writes_file = 1'b1;
    end
  end

endmodule // lbd_decode
`default_nettype wire

// *** design/lbd_defs.svh ***
// Constants for the logic, branch and bit-clear decode block
`ifndef LBD_DEFS_SVH
`define LBD_DEFS_SVH

// ----------------------------------------------------------------------
// Opcode fields
// ----------------------------------------------------------------------
`define LBD_OPC_AND_LIT 8'h0b
`define LBD_OPC_AND_FILE 6'h05
`define LBD_OPC_BR_C 8'he2
`define LBD_OPC_BR_N 8'he6
`define LBD_OPC_BCLR 4'h9

// ----------------------------------------------------------------------
// Field positions inside the instruction word
// ----------------------------------------------------------------------
`define LBD_DEST_POS 9
`define LBD_BANK_POS 8
`define LBD_BSEL_HI 11
`define LBD_BSEL_LO 9
`define LBD_SIGN_POS 7

// ----------------------------------------------------------------------
// Reset values, access bank and timing
// ----------------------------------------------------------------------
`define LBD_W_RST 8'h00
`define LBD_STAT_RST 5'h00
`define LBD_IR_RST 16'h0000
`define LBD_ACCESS_SPLIT 8'h80
`define LBD_ACCESS_LO_BANK 4'h0
`define LBD_ACCESS_HI_BANK 4'hf
`define LBD_QPHASES 4
`define LBD_PC_STEP 2

`endif

// *** design/lbd_pkg.sv ***
// Types shared by the logic, branch and bit-clear decode block
package lbd_pkg;

  typedef enum logic [1:0] {
    PH_Q1 = 2'b00,
    PH_Q2 = 2'b01,
    PH_Q3 = 2'b10,
    PH_Q4 = 2'b11
  } lbd_phase_e;

  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_AND_LIT = 3'b001,
    OP_AND_FILE = 3'b010,
    OP_BR_C = 3'b011,
    OP_BR_N = 3'b100,
    OP_BCLR = 3'b101
  } lbd_op_e;

  typedef struct packed {
    lbd_op_e op;
    logic writes_file;
    logic bank_bit;
    logic [2:0] bitsel;
    logic [7:0] fadr;
  } lbd_dec_s;

  typedef struct packed {
    logic n;
    logic ov;
    logic z;
    logic dc;
    logic c;
  } lbd_stat_s;

  typedef struct packed {
    logic rd;
    logic we;
    logic [11:0] addr;
    logic [7:0] wdata;
  } lbd_mem_req_s;

endpackage : lbd_pkg

// *** test/lbd_mem_model.sv ***
// Program memory and banked data memory facing the execute unit
`timescale 1ns/1ps
`default_nettype none

module lbd_mem_model #(
  parameter int PC_W = 21
) (
  // Clock
  input wire logic clk_in,
  input wire logic ce_in,
  // Program side
  input wire logic [PC_W-1:0] pc_in,
  output logic [15:0] instr_out,
  // Data side
  input wire lbd_pkg::lbd_mem_req_s mem_req_in,
  output logic [7:0] rdata_out
);
  import lbd_pkg::*;

  logic [15:0] rom [256];
  logic [7:0] ram [4096];
  logic [7:0] last_ff = 8'h00;

  // Words sit at even byte addresses
  assign instr_out = rom[pc_in[8:1]];
  // An idle read port shows the inverse of its last value, so a late sample cannot pass
  assign rdata_out = mem_req_in.rd ? ram[mem_req_in.addr] : ~last_ff;

  always @(posedge clk_in) begin
    if (ce_in && mem_req_in.rd) begin
      last_ff <= ram[mem_req_in.addr];
    end
    if (ce_in && mem_req_in.we) begin
      ram[mem_req_in.addr] <= mem_req_in.wdata;
    end
  end
endmodule // lbd_mem_model

`default_nettype wire

// *** test/logic_branch_bitclear_decode_tb_top.sv ***
// Self-checking bench for the four-phase execute unit
`timescale 1ns/1ps
`default_nettype none

module logic_branch_bitclear_decode_tb_top;
  import lbd_pkg::*;

  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic ce_in = 1'b1;
  logic [3:0] bank_sel_in = 4'h0;
  logic w_load_in = 1'b0;
  logic [7:0] w_data_in = 8'h00;
  logic flag_load_in = 1'b0;
  lbd_stat_s flag_data_in = 5'h00;
  logic [15:0] instr_in;
  logic [7:0] mem_rdata_in;
  logic fetch_out;
  logic [20:0] pc_out;
  lbd_mem_req_s mem_req_out;
  logic [7:0] w_out;
  lbd_stat_s status_out;
  lbd_phase_e phase_out;
  logic taken_out;
  logic nop_cycle_out;
  logic unknown_op_out;
  int err_total = 0;
  int cmp_count = 0;

  always #4 clk_in = ~clk_in;

  lbd_core #(.PC_W(21)) i_lbd_core (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .ce_in(ce_in),
    .instr_in(instr_in), .fetch_out(fetch_out), .pc_out(pc_out),
    .bank_sel_in(bank_sel_in), .mem_rdata_in(mem_rdata_in), .mem_req_out(mem_req_out),
    .w_load_in(w_load_in), .w_data_in(w_data_in),
    .flag_load_in(flag_load_in), .flag_data_in(flag_data_in),
    .w_out(w_out), .status_out(status_out), .phase_out(phase_out),
    .taken_out(taken_out), .nop_cycle_out(nop_cycle_out), .unknown_op_out(unknown_op_out)
  );

  lbd_mem_model #(.PC_W(21)) i_lbd_mem_model (
    .clk_in(clk_in), .ce_in(ce_in), .pc_in(pc_out), .instr_out(instr_in),
    .mem_req_in(mem_req_out), .rdata_out(mem_rdata_in)
  );

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic step(input int edges);
    repeat (edges) @(posedge clk_in);
    #1;
  endtask

  // Fill with an undecoded word so stray fetches only advance the PC
  task automatic clear_rom();
    for (int i = 0; i < 256; i++) begin
      i_lbd_mem_model.rom[i] = 16'hffff;
    end
  endtask

  // Returns at the edge where the first instruction is taken; W and flags load there
  task automatic restart(input int cyc, input logic [7:0] w, input logic [4:0] fl);
    @(posedge clk_in);
    reset_n_in <= 1'b0;
    w_data_in <= w;
    flag_data_in <= fl;
    repeat (cyc) @(posedge clk_in);
    reset_n_in <= 1'b1;
    w_load_in <= 1'b1;
    flag_load_in <= 1'b1;
    @(posedge clk_in);
    w_load_in <= 1'b0;
    flag_load_in <= 1'b0;
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_and_lit();
    clear_rom();
    i_lbd_mem_model.rom[0] = 16'h0bff;
    i_lbd_mem_model.rom[1] = 16'h0b5f;
    i_lbd_mem_model.rom[2] = 16'h0b00;
    restart(4, 8'ha3, 5'h0b);
    step(3);
    check("w lit ff", w_out, 8'ha3);
    check("flags neg", status_out, 5'h1b);
    check("phase wrapped", phase_out, PH_Q1);
    check("op known", unknown_op_out, 1'b0);
    step(4);
    check("w lit 5f", w_out, 8'h03);
    check("flags kept", status_out, 5'h0b);
    step(4);
    check("w lit 00", w_out, 8'h00);
    check("flags zero", status_out, 5'h0f);
    $display("test and_literal done");
  endtask

  task automatic t_and_file();
    clear_rom();
    i_lbd_mem_model.ram[12'hf90] = 8'h81;
    i_lbd_mem_model.ram[12'h010] = 8'hc2;
    i_lbd_mem_model.ram[12'h390] = 8'hf0;
    i_lbd_mem_model.rom[0] = 16'h1690;
    i_lbd_mem_model.rom[1] = 16'h1410;
    i_lbd_mem_model.rom[2] = 16'h1790;
    restart(2, 8'h17, 5'h00);
    bank_sel_in <= 4'h3;
    step(3);
    check("ram f90", i_lbd_mem_model.ram[12'hf90], 8'h01);
    check("w kept", w_out, 8'h17);
    step(4);
    check("w file", w_out, 8'h02);
    check("ram 010 kept", i_lbd_mem_model.ram[12'h010], 8'hc2);
    check("flags nz clear", status_out, 5'h00);
    step(4);
    check("ram 390", i_lbd_mem_model.ram[12'h390], 8'h00);
    check("ram f90 kept", i_lbd_mem_model.ram[12'hf90], 8'h01);
    check("flags z", status_out, 5'h04);
    $display("test and_file done");
  endtask

  task automatic t_bit_clear();
    logic [7:0] e;
    clear_rom();
    i_lbd_mem_model.ram[12'h020] = 8'hff;
    for (int b = 0; b < 8; b++) begin
      i_lbd_mem_model.rom[b] = {4'h9, 3'(b), 1'b0, 8'h20};
    end
    restart(2, 8'h00, 5'h1f);
    step(3);
    for (int b = 0; b < 8; b++) begin
      e = 8'hff << (b + 1);
      check("ram 020", i_lbd_mem_model.ram[12'h020], e);
      check("flags bclr", status_out, 5'h1f);
      step(4);
    end
    $display("test bit_clear done");
  endtask

  task automatic t_branch(input logic [7:0] opc, input logic [4:0] fl, input int at,
                          input int off, input logic tk);
    logic [31:0] tgt;
    clear_rom();
    i_lbd_mem_model.rom[at] = {opc, 8'(off)};
    restart(2, 8'h00, fl);
    tgt = tk ? at * 2 + 2 + 2 * off : at * 2 + 2;
    step(4 * at + 2);
    check("taken", taken_out, tk);
    step(1);
    check("pc after branch", pc_out, tgt);
    check("idle cycle", nop_cycle_out, tk);
    check("fetch", fetch_out, !tk);
    check("flags branch", status_out, fl);
    step(4);
    check("pc next", pc_out, tk ? tgt : at * 2 + 4);
    check("idle over", nop_cycle_out, 1'b0);
    check("no-op latched", unknown_op_out, 1'b1);
    $display("test branch %h done", opc);
  endtask

  // Enable low in Q2 must hold phase, PC and W until it returns
  task automatic t_clock_hold();
    clear_rom();
    i_lbd_mem_model.rom[0] = 16'h0b0f;
    restart(2, 8'h3c, 5'h00);
    ce_in <= 1'b0;
    step(4);
    check("phase held", phase_out, PH_Q2);
    check("w held", w_out, 8'h3c);
    check("pc held", pc_out, 21'h000002);
    @(posedge clk_in);
    ce_in <= 1'b1;
    step(3);
    check("w after hold", w_out, 8'h0c);
    check("phase after hold", phase_out, PH_Q1);
    $display("test clock_hold done");
  endtask

  // ----------------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------------
  initial begin
    t_and_lit();
    t_and_file();
    t_bit_clear();
    t_branch(8'he2, 5'h01, 0, 3, 1'b1);
    t_branch(8'he2, 5'h10, 0, 3, 1'b0);
    t_branch(8'he6, 5'h10, 0, 127, 1'b1);
    t_branch(8'he6, 5'h01, 0, 127, 1'b0);
    t_branch(8'he6, 5'h11, 127, -128, 1'b1);
    t_branch(8'he2, 5'h1f, 127, -128, 1'b1);
    t_clock_hold();
    tally_and_finish();
  end

  // About 1200 cycles are needed; allow roughly five times that
  initial begin
    #50000;
    err_total++;
    $display("watchdog expired");
    tally_and_finish();
  end
endmodule // logic_branch_bitclear_decode_tb_top

`default_nettype wire
